//--- src/lecr_pkg.sv
// Package for the link error, identification and control register bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit bus.
package lecr_pkg;

  // Register byte offsets
  localparam logic [7:0] LECR_OFS_CAPTURE_HIGH = 8'h3c;
  localparam logic [7:0] LECR_OFS_VENDOR_CODE = 8'h40;
  localparam logic [7:0] LECR_OFS_FLAGS_SET = 8'h50;
  localparam logic [7:0] LECR_OFS_FLAGS_CLEAR = 8'h54;
  localparam logic [7:0] LECR_OFS_INT_STATUS = 8'h58;
  localparam logic [7:0] LECR_OFS_INT_CLEAR = 8'h5c;
  localparam logic [7:0] LECR_OFS_INT_ENABLE = 8'h60;

  // Capture register field positions
  localparam int LECR_SRC_BUS_MSB = 31;
  localparam int LECR_SRC_BUS_LSB = 22;
  localparam int LECR_SRC_NODE_MSB = 21;
  localparam int LECR_SRC_NODE_LSB = 16;
  localparam int LECR_OFFSET_UPPER_MSB = 15;

  // Control flag positions
  localparam int LECR_BIT_BUS_INFO_IMAGE_VALID = 31;
  localparam int LECR_BIT_LINK_ENABLE = 17;
  localparam int LECR_BIT_SOFT_RESET = 16;

  // Flags software may set and clear: 31, 30, 29, 22, 19, 18, 17, 16
  localparam logic [31:0] LECR_FLAGS_SC_MASK = 32'he04f0000;
  // Fixed one: bit 23 reads as 1; all other read-only bits read 0
  localparam logic [31:0] LECR_FLAGS_FIXED_ONES = 32'h00800000;
  localparam logic [31:0] LECR_FLAGS_RESET = 32'h00800000;
  localparam logic [31:0] LECR_CAPTURE_RESET = 32'h00000000;

  // Arbitrary neutral identification value
  localparam logic [31:0] LECR_VENDOR_CODE_DEFAULT = 32'h00a5a5a5;

  // Interrupt event bits
  localparam int LECR_EV_COUNT = 2;
  localparam int LECR_EV_POSTED_FAIL = 0;
  localparam int LECR_EV_FETCH_ERROR = 1;
  localparam logic [LECR_EV_COUNT-1:0] LECR_EV_RESET = 2'h0;

  // Failed posted write report from the link side
  typedef struct packed {
    logic valid;
    logic [9:0] bus_number;
    logic [5:0] node_number;
    logic [15:0] offset_upper;
  } lecr_fail_report_t;

  // All state of the register bank
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] capture_high;
    logic [31:0] flags;
    logic [LECR_EV_COUNT-1:0] int_status;
    logic [LECR_EV_COUNT-1:0] int_enable;
  } lecr_state_t;

endpackage

//--- src/lecr_regs.sv
// Register bank: failed posted write capture, vendor code, controller flags.
// Assumes a classic Wishbone master on core_clk; event inputs are core_clk pulses.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module lecr_regs
  import lecr_pkg::*;
#(
  parameter logic [31:0] VENDOR_CODE = LECR_VENDOR_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link side events
  input wire lecr_fail_report_t fail_report,
  input wire logic bus_info_fetch_error,
  input wire logic soft_reset_done,
  // Controller state
  output logic [31:0] controller_flags,
  output logic bus_info_image_valid,
  output logic link_enable_flag,
  output logic irq
);

  function automatic logic [31:0] lecr_byte_mask(input logic [3:0] sel);
    lecr_byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic lecr_hit(input logic [7:0] adr, input logic [7:0] ofs);
    lecr_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  lecr_state_t st;
  lecr_state_t next_st;

  logic req;
  logic wr;
  logic [31:0] wbits;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [LECR_EV_COUNT-1:0] events;
  logic [31:0] rd_value;

  // A request is seen for one cycle before ack; the write lands on the ack edge
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
  assign wbits = wb_dat_i & lecr_byte_mask(wb_sel_i);
  assign events = {bus_info_fetch_error, fail_report.valid};

  always_comb begin
    rd_value = 32'h00000000;
    if (lecr_hit(wb_adr_i, LECR_OFS_CAPTURE_HIGH)) begin
      rd_value = st.capture_high;
    end else if (lecr_hit(wb_adr_i, LECR_OFS_VENDOR_CODE)) begin
      rd_value = VENDOR_CODE;
    end else if (lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET) ||
                 lecr_hit(wb_adr_i, LECR_OFS_FLAGS_CLEAR)) begin
      rd_value = st.flags;
    end else if (lecr_hit(wb_adr_i, LECR_OFS_INT_STATUS)) begin
      rd_value = {{(32-LECR_EV_COUNT){1'b0}}, st.int_status};
    end else if (lecr_hit(wb_adr_i, LECR_OFS_INT_ENABLE)) begin
      rd_value = {{(32-LECR_EV_COUNT){1'b0}}, st.int_enable};
    end
  end

  always_comb begin
    next_st = st;
    set_bits = 32'h00000000;
    clr_bits = 32'h00000000;
    next_st.ack = req;
    if (req) begin
      next_st.rdata = rd_value;
    end
    // Writes to the vendor code and capture register fall through with no effect
    if (wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET)) begin
      set_bits = wbits & LECR_FLAGS_SC_MASK;
      if (st.flags[LECR_BIT_LINK_ENABLE]) begin
        set_bits[LECR_BIT_BUS_INFO_IMAGE_VALID] = 1'b0;
      end
    end
    if (wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_CLEAR)) begin
      clr_bits = wbits & LECR_FLAGS_SC_MASK;
    end
    next_st.flags = ((st.flags | set_bits) & ~clr_bits & LECR_FLAGS_SC_MASK)
                    | LECR_FLAGS_FIXED_ONES;
    if (soft_reset_done) begin
      next_st.flags[LECR_BIT_SOFT_RESET] = 1'b0;
    end
    // Hardware invalidation beats a simultaneous software set: stale image is worse
    if (bus_info_fetch_error || st.flags[LECR_BIT_SOFT_RESET]) begin
      next_st.flags[LECR_BIT_BUS_INFO_IMAGE_VALID] = 1'b0;
    end
    if (fail_report.valid) begin
      next_st.capture_high = {fail_report.bus_number, fail_report.node_number,
                              fail_report.offset_upper};
    end
    if (wr && lecr_hit(wb_adr_i, LECR_OFS_INT_ENABLE)) begin
      next_st.int_enable = wbits[LECR_EV_COUNT-1:0];
    end
    // New events win over a clear in the same cycle
    if (wr && lecr_hit(wb_adr_i, LECR_OFS_INT_CLEAR)) begin
      next_st.int_status = (st.int_status & ~wbits[LECR_EV_COUNT-1:0]) | events;
    end else begin
      next_st.int_status = st.int_status | events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.ack <= 1'b0;
      st.rdata <= 32'h00000000;
      st.capture_high <= LECR_CAPTURE_RESET;
      st.flags <= LECR_FLAGS_RESET;
      st.int_status <= LECR_EV_RESET;
      st.int_enable <= LECR_EV_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign controller_flags = st.flags;
  assign bus_info_image_valid = st.flags[LECR_BIT_BUS_INFO_IMAGE_VALID];
  assign link_enable_flag = st.flags[LECR_BIT_LINK_ENABLE];
  assign irq = |(st.int_status & st.int_enable);

  // Flags whose set write has no side condition and no competing hardware clear
  localparam logic [31:0] PLAIN_FLAGS_MASK = LECR_FLAGS_SC_MASK &
    ~((32'h00000001 << LECR_BIT_BUS_INFO_IMAGE_VALID) | (32'h00000001 << LECR_BIT_SOFT_RESET));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_capture_loads;
    fail_report.valid |=> st.capture_high[15:0] == $past(fail_report.offset_upper);
  endproperty
  a_capture_loads: assert property (p_capture_loads)
    else $error("capture register not loaded on failed write");

  property p_capture_source;
    fail_report.valid |=>
      st.capture_high[LECR_SRC_BUS_MSB:LECR_SRC_BUS_LSB] == $past(fail_report.bus_number) &&
      st.capture_high[LECR_SRC_NODE_MSB:LECR_SRC_NODE_LSB] == $past(fail_report.node_number);
  endproperty
  a_capture_source: assert property (p_capture_source)
    else $error("requester identifier misplaced in capture register");

  property p_capture_holds;
    !fail_report.valid |=> $stable(st.capture_high[LECR_OFFSET_UPPER_MSB:0]);
  endproperty
  a_capture_holds: assert property (p_capture_holds)
    else $error("capture offset changed without a failure");

  property p_vendor_read;
    req && !wb_we_i && lecr_hit(wb_adr_i, LECR_OFS_VENDOR_CODE) |=>
      wb_ack_o && wb_dat_o == VENDOR_CODE;
  endproperty
  a_vendor_read: assert property (p_vendor_read)
    else $error("vendor code read wrong");

  property p_set_offset;
    wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET) && wb_sel_i[3] && wb_dat_i[30] |=>
      controller_flags[30];
  endproperty
  a_set_offset: assert property (p_set_offset)
    else $error("set offset did not set flag");

  property p_readonly_bits;
    (controller_flags & ~LECR_FLAGS_SC_MASK) == LECR_FLAGS_FIXED_ONES;
  endproperty
  a_readonly_bits: assert property (p_readonly_bits)
    else $error("read-only flag bits wrong");

  property p_clear_offset;
    wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_CLEAR) && wb_sel_i[2] && wb_dat_i[22] |=>
      !controller_flags[22];
  endproperty
  a_clear_offset: assert property (p_clear_offset)
    else $error("clear offset did not clear flag");

  property p_image_valid_guard;
    link_enable_flag && !bus_info_image_valid |=> !bus_info_image_valid;
  endproperty
  a_image_valid_guard: assert property (p_image_valid_guard)
    else $error("image valid set while link enabled");

  property p_fetch_error_clears;
    bus_info_fetch_error |=> !bus_info_image_valid;
  endproperty
  a_fetch_error_clears: assert property (p_fetch_error_clears)
    else $error("fetch error did not clear image valid");

  property p_irq_level;
    ##1 $rose(st.int_status[LECR_EV_POSTED_FAIL]) && st.int_enable[LECR_EV_POSTED_FAIL] |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt missing for enabled event");

  // Bus handshake, register read-back, flag writes and hardware flag clears
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_request_answered;
    req |=> wb_ack_o;
  endproperty
  a_request_answered: assert property (p_request_answered)
    else $error("request not acknowledged in the next cycle");

  property p_dat_holds;
    !req |=> $stable(wb_dat_o);
  endproperty
  a_dat_holds: assert property (p_dat_holds)
    else $error("read data changed without a request");

  property p_capture_read;
    req && !wb_we_i && lecr_hit(wb_adr_i, LECR_OFS_CAPTURE_HIGH) |=>
      wb_dat_o == $past(st.capture_high);
  endproperty
  a_capture_read: assert property (p_capture_read)
    else $error("capture register read wrong");

  property p_capture_write_ignored;
    wr && lecr_hit(wb_adr_i, LECR_OFS_CAPTURE_HIGH) && !fail_report.valid |=>
      $stable(st.capture_high);
  endproperty
  a_capture_write_ignored: assert property (p_capture_write_ignored)
    else $error("software write changed capture register");

  property p_flags_read;
    req && !wb_we_i && (lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET) ||
                        lecr_hit(wb_adr_i, LECR_OFS_FLAGS_CLEAR)) |=>
      wb_dat_o == $past(controller_flags);
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flag read-back wrong");

  property p_flags_rise_by_set_only;
    !(wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET)) |=>
      (controller_flags & ~$past(controller_flags)) == 32'h00000000;
  endproperty
  a_flags_rise_by_set_only: assert property (p_flags_rise_by_set_only)
    else $error("flag rose without a set write");

  // Hardware clears may land with a set write, so only plain flags are checked here
  property p_set_write_effect;
    wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET) |=>
      (controller_flags & lecr_byte_mask($past(wb_sel_i)) & $past(wb_dat_i) &
       PLAIN_FLAGS_MASK) ==
      (lecr_byte_mask($past(wb_sel_i)) & $past(wb_dat_i) & PLAIN_FLAGS_MASK);
  endproperty
  a_set_write_effect: assert property (p_set_write_effect)
    else $error("set write left a flag clear");

  property p_clear_write_effect;
    wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_CLEAR) |=>
      (controller_flags & lecr_byte_mask($past(wb_sel_i)) & $past(wb_dat_i) &
       LECR_FLAGS_SC_MASK) == 32'h00000000;
  endproperty
  a_clear_write_effect: assert property (p_clear_write_effect)
    else $error("clear write left a flag set");

  property p_image_valid_set;
    wr && lecr_hit(wb_adr_i, LECR_OFS_FLAGS_SET) && wb_sel_i[3] && wb_dat_i[31] &&
      !link_enable_flag && !bus_info_fetch_error && !controller_flags[LECR_BIT_SOFT_RESET] |=>
      bus_info_image_valid;
  endproperty
  a_image_valid_set: assert property (p_image_valid_set)
    else $error("image valid not set while link disabled");

  property p_soft_reset_invalidates;
    controller_flags[LECR_BIT_SOFT_RESET] |=> !bus_info_image_valid;
  endproperty
  a_soft_reset_invalidates: assert property (p_soft_reset_invalidates)
    else $error("software reset did not clear image valid");

  property p_soft_reset_done_clears;
    soft_reset_done |=> !controller_flags[LECR_BIT_SOFT_RESET];
  endproperty
  a_soft_reset_done_clears: assert property (p_soft_reset_done_clears)
    else $error("soft reset flag not cleared on completion");

  // Interrupt status: events win over a clear, bits stay until cleared
  property p_status_on_posted_fail;
    fail_report.valid |=> st.int_status[LECR_EV_POSTED_FAIL];
  endproperty
  a_status_on_posted_fail: assert property (p_status_on_posted_fail)
    else $error("posted failure not recorded in status");

  property p_status_on_fetch_error;
    bus_info_fetch_error |=> st.int_status[LECR_EV_FETCH_ERROR];
  endproperty
  a_status_on_fetch_error: assert property (p_status_on_fetch_error)
    else $error("fetch error not recorded in status");

  property p_status_sticky;
    st.int_status[LECR_EV_POSTED_FAIL] && !(wr && lecr_hit(wb_adr_i, LECR_OFS_INT_CLEAR)) |=>
      st.int_status[LECR_EV_POSTED_FAIL];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clear");

  property p_status_clear;
    wr && lecr_hit(wb_adr_i, LECR_OFS_INT_CLEAR) && wb_sel_i[0] &&
      wb_dat_i[LECR_EV_FETCH_ERROR] && !bus_info_fetch_error |=>
      !st.int_status[LECR_EV_FETCH_ERROR];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit not cleared by clear write");

  property p_int_enable_write;
    wr && lecr_hit(wb_adr_i, LECR_OFS_INT_ENABLE) && wb_sel_i[0] |=>
      st.int_enable == $past(wb_dat_i[LECR_EV_COUNT-1:0]);
  endproperty
  a_int_enable_write: assert property (p_int_enable_write)
    else $error("interrupt enable write not stored");

  c_fail_capture: cover property (fail_report.valid ##1 wb_ack_o);
  c_image_valid_set: cover property ($rose(bus_info_image_valid));
  c_fetch_error: cover property (bus_info_image_valid ##1 bus_info_fetch_error);
  c_irq: cover property ($rose(irq));
  c_soft_reset_invalidates: cover property (bus_info_image_valid &&
                                            controller_flags[LECR_BIT_SOFT_RESET]);

endmodule // lecr_regs

`default_nettype wire

//--- bench/lecr_regs_test.sv
// Self-checking bench for the link error, identification and control register bank.
// Assumes lecr_pkg is compiled first; the bench drives every port of lecr_regs itself.
`timescale 1ns/1ps
`default_nettype none

module lecr_regs_test;
  import lecr_pkg::*;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  lecr_fail_report_t fail_report = '0;
  logic bus_info_fetch_error = 1'b0;
  logic soft_reset_done = 1'b0;
  logic [31:0] controller_flags;
  logic bus_info_image_valid;
  logic link_enable_flag;
  logic irq;
  logic [31:0] seed = 32'hbacd;
  logic [31:0] exp_q[$];
  logic [31:0] ex;
  logic [31:0] r;
  int n_fail = 0;
  int samples_checked = 0;

  always #2.5 core_clk = ~core_clk;

  lecr_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fail_report(fail_report), .bus_info_fetch_error(bus_info_fetch_error),
    .soft_reset_done(soft_reset_done), .controller_flags(controller_flags),
    .bus_info_image_valid(bus_info_image_valid), .link_enable_flag(link_enable_flag),
    .irq(irq));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic close_out();
    // A read note never matched by an answer is a mismatch too
    if (exp_q.size() > 0) begin
      n_fail++;
    end
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask

  // Request held until ack is sampled high, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      chk("ack_timeout", 32'h1, 32'h0);
      close_out();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, 4'hf, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, adr, 4'hf, 32'h0);
  endtask

  task automatic pulse(input logic fetch_err);
    if (fetch_err) begin
      bus_info_fetch_error <= 1'b1;
    end else begin
      soft_reset_done <= 1'b1;
    end
    @(posedge core_clk);
    bus_info_fetch_error <= 1'b0;
    soft_reset_done <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data is judged where ack is sampled, against the oldest note
  always @(posedge core_clk) begin
    if (rst_n && wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() > 0) begin
        chk("rdata", exp_q.pop_front(), wb_dat_o);
      end else begin
        chk("rdata_note", 32'h1, 32'h0);
      end
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h50, LECR_FLAGS_RESET);
    rd(8'h54, LECR_FLAGS_RESET);
    rd(8'h3c, LECR_CAPTURE_RESET);
    rd(8'h44, 32'h0);
    wr(8'h40, 32'hffffffff);
    wr(8'h3c, 32'hffffffff);
    rd(8'h40, LECR_VENDOR_CODE_DEFAULT);
    rd(8'h3c, LECR_CAPTURE_RESET);
    // Bits 31 and 16 kept out of random sets: they carry side effects
    ex = LECR_FLAGS_RESET;
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      wr(i[0] ? 8'h54 : 8'h50, i[0] ? r : (r & 32'h7ffeffff));
      ex = i[0] ? (ex & ~(r & LECR_FLAGS_SC_MASK)) : (ex | (r & 32'h604e0000));
      rd(i[1] ? 8'h54 : 8'h50, ex);
      chk("controller_flags", ex, controller_flags);
    end
    wr(8'h54, 32'hffffffff);
    bus(1'b1, 8'h50, 4'h4, 32'hffffffff);
    ex = 32'h00cf0000;
    rd(8'h54, ex);
    chk("link_enable", 32'h1, {31'h0, link_enable_flag});
    pulse(1'b0);
    ex = 32'h00ce0000;
    rd(8'h50, ex);
    wr(8'h50, 32'h80000000);
    rd(8'h50, ex);
    wr(8'h54, 32'h00020000);
    wr(8'h50, 32'h80000000);
    chk("image_valid", 32'h1, {31'h0, bus_info_image_valid});
    pulse(1'b1);
    rd(8'h50, 32'h00cc0000);
    wr(8'h50, 32'h80000000);
    wr(8'h50, 32'h00010000);
    rd(8'h54, 32'h00cd0000);
    wr(8'h54, 32'h00010000);
    wr(8'h60, 32'h3);
    rd(8'h58, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h5c, 32'h2);
    rd(8'h58, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    r = rnd();
    fail_report <= {1'b1, r};
    @(posedge core_clk);
    fail_report <= {1'b0, ~r};
    @(posedge core_clk);
    rd(8'h3c, r);
    rd(8'h58, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h60, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h5c, 32'h1);
    rd(8'h58, 32'h0);
    // Hardware reset in mid-run must drop the image valid flag and the capture
    wr(8'h50, 32'h80000000);
    chk("image_valid", 32'h1, {31'h0, bus_info_image_valid});
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("image_valid", 32'h0, {31'h0, bus_info_image_valid});
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h50, LECR_FLAGS_RESET);
    rd(8'h3c, LECR_CAPTURE_RESET);
    close_out();
  end

endmodule // lecr_regs_test

`default_nettype wire
